/* File: common/mcp_pkg.sv */
package mcp_pkg;
	// register byte offsets on the wishbone slave
	localparam int unsigned ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_FLAGS = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_MASK = 8'h0c;
	localparam logic [7:0] OFF_INFO = 8'h10;

	// control register fields
	localparam int unsigned CTRL_IRQ_EDGE = 0;
	localparam int unsigned CTRL_CLK_OFF = 1;
	localparam int unsigned CTRL_W = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// condition flags register: nonmaskable mask bit
	localparam int unsigned FLAGS_XMASK = 0;

	// status and mask layout
	localparam int unsigned ST_IRQ = 0;
	localparam int unsigned ST_NMI = 1;
	localparam int unsigned ST_RST_INT = 2;
	localparam int unsigned ST_RST_EXT = 3;
	localparam int unsigned ST_W = 4;
	localparam logic [3:0] STATUS_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;

	// info register fields
	localparam int unsigned INFO_MODE_LSB = 0;
	localparam int unsigned INFO_CAUSE_LSB = 4;
	localparam int unsigned INFO_RST_ACTIVE = 8;
	localparam int unsigned INFO_CLK_ON = 9;

	// bus-phase clock: oscillator input divided by four
	localparam int unsigned CLK_DIV = 4;
	localparam logic [1:0] PHASE_HIGH_START = 2'h2;
	localparam logic [1:0] PHASE_LAST = 2'h3;

	// reset pin timing in bus-phase clock cycles
	localparam logic [2:0] RESET_SENSE_BUS_CYCLES = 3'h2;
	localparam logic [2:0] RESET_DRIVE_BUS_CYCLES = 3'h4;

	// operating mode, {mode_select_high, mode_select_low}
	typedef enum logic [1:0] {
		MODE_BOOTSTRAP = 2'h0,
		MODE_TEST = 2'h1,
		MODE_SINGLE = 2'h2,
		MODE_EXPANDED = 2'h3
	} mcp_mode_t;

	typedef enum logic [1:0] {
		CAUSE_NONE = 2'h0,
		CAUSE_EXTERNAL = 2'h1,
		CAUSE_CLOCK_MON = 2'h2,
		CAUSE_WATCHDOG = 2'h3
	} mcp_cause_t;

	typedef enum logic [1:0] {
		RS_RUN,
		RS_DRIVE,
		RS_SENSE,
		RS_WAIT_HIGH
	} mcp_rst_state_t;

	// synchroniser lane indices
	localparam int unsigned SY_RST = 0;
	localparam int unsigned SY_IRQ = 1;
	localparam int unsigned SY_NMI = 2;
	localparam int unsigned SY_MODE_LO = 3;
	localparam int unsigned SY_MODE_HI = 4;
	localparam int unsigned SY_N = 5;
endpackage : mcp_pkg

/* File: logic/mcp_control_pins.sv */
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module mcp_control_pins #(
	parameter bit CLOCK_OUT_ALWAYS_ON = 1'b0,
	parameter logic [2:0] DRIVE_BUS_CYCLES = mcp_pkg::RESET_DRIVE_BUS_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [mcp_pkg::ADDR_W-1:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	output logic o_irq,
	input wire logic i_reset_pin,
	output logic o_reset_pin,
	output logic o_reset_pin_oe,
	input wire logic i_clock_monitor_fail,
	input wire logic i_watchdog_monitor_fail,
	output logic o_reset_active,
	input wire logic i_stop,
	output logic o_bus_clock,
	output logic o_access_phase,
	output logic o_bus_cycle_end,
	input wire logic i_irq_n,
	input wire logic i_irq_ack,
	input wire logic i_irq_mask,
	output logic o_cpu_irq,
	input wire logic i_nonmaskable_interrupt_request_n,
	output logic o_cpu_nmi,
	input wire logic i_mode_select_low,
	output logic o_mode_select_low,
	output logic o_mode_select_low_oe,
	input wire logic i_mode_select_high,
	input wire logic i_opcode_fetch,
	output logic [1:0] o_mode
);
	// synchronisers: first stage feeds only the second stage
	logic [mcp_pkg::SY_N-1:0] sync_raw;
	logic [mcp_pkg::SY_N-1:0] sync_1;
	logic [mcp_pkg::SY_N-1:0] sync_2;

	assign sync_raw[mcp_pkg::SY_RST] = i_reset_pin;
	assign sync_raw[mcp_pkg::SY_IRQ] = i_irq_n;
	assign sync_raw[mcp_pkg::SY_NMI] = i_nonmaskable_interrupt_request_n;
	assign sync_raw[mcp_pkg::SY_MODE_LO] = i_mode_select_low;
	assign sync_raw[mcp_pkg::SY_MODE_HI] = i_mode_select_high;

	genvar gi;
	generate
		for (gi = 0; gi < mcp_pkg::SY_N; gi++) begin : g_sync
			// idle high so a quiet pin is not seen low after reset
			always_ff @(posedge i_clk_sys or posedge i_reset) begin
				if (i_reset) begin
					sync_1[gi] <= 1'b1;
					sync_2[gi] <= 1'b1;
				end else begin
					sync_1[gi] <= sync_raw[gi];
					sync_2[gi] <= sync_1[gi];
				end
			end
		end
	endgenerate

	logic pin_low;
	logic irq_low;
	logic nmi_low;
	assign pin_low = ~sync_2[mcp_pkg::SY_RST];
	assign irq_low = ~sync_2[mcp_pkg::SY_IRQ];
	assign nmi_low = ~sync_2[mcp_pkg::SY_NMI];

	// reset sequencer state
	mcp_pkg::mcp_rst_state_t rst_state, next_rst_state;
	logic [2:0] rst_cnt, next_rst_cnt;
	logic [1:0] cause, next_cause;
	logic ev_rst_int;
	logic ev_rst_ext;
	logic in_reset;
	logic bus_tick;

	assign in_reset = (rst_state != mcp_pkg::RS_RUN);

	always_comb begin
		next_rst_state = rst_state;
		next_rst_cnt = rst_cnt;
		next_cause = cause;
		ev_rst_int = 1'b0;
		ev_rst_ext = 1'b0;
		unique case (rst_state)
			mcp_pkg::RS_RUN: begin
				next_rst_cnt = 3'h0;
				if (i_clock_monitor_fail) begin
					next_rst_state = mcp_pkg::RS_DRIVE;
					next_cause = mcp_pkg::CAUSE_CLOCK_MON;
				end else if (i_watchdog_monitor_fail) begin
					next_rst_state = mcp_pkg::RS_DRIVE;
					next_cause = mcp_pkg::CAUSE_WATCHDOG;
				end else if (pin_low) begin
					next_rst_state = mcp_pkg::RS_SENSE;
					next_cause = mcp_pkg::CAUSE_NONE;
				end
			end
			mcp_pkg::RS_DRIVE: begin
				if (bus_tick) begin
					if (rst_cnt == DRIVE_BUS_CYCLES - 3'h1) begin
						next_rst_state = mcp_pkg::RS_SENSE;
						next_rst_cnt = 3'h0;
					end else begin
						next_rst_cnt = rst_cnt + 3'h1;
					end
				end
			end
			mcp_pkg::RS_SENSE: begin
				// a pin that rises early counts as an internal reset, also after a short external pull seen in RS_RUN
				if (!pin_low) begin
					next_rst_state = mcp_pkg::RS_RUN;
					ev_rst_int = 1'b1;
				end else if (bus_tick) begin
					if (rst_cnt == mcp_pkg::RESET_SENSE_BUS_CYCLES - 3'h1) begin
						next_rst_state = mcp_pkg::RS_WAIT_HIGH;
						next_cause = mcp_pkg::CAUSE_EXTERNAL;
						ev_rst_ext = 1'b1;
					end else begin
						next_rst_cnt = rst_cnt + 3'h1;
					end
				end
			end
			mcp_pkg::RS_WAIT_HIGH: begin
				if (!pin_low) begin
					next_rst_state = mcp_pkg::RS_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			rst_state <= mcp_pkg::RS_RUN;
			rst_cnt <= 3'h0;
			cause <= mcp_pkg::CAUSE_NONE;
		end else begin
			rst_state <= next_rst_state;
			rst_cnt <= next_rst_cnt;
			cause <= next_cause;
		end
	end

	assign o_reset_pin = 1'b0;
	assign o_reset_pin_oe = (rst_state == mcp_pkg::RS_DRIVE);
	assign o_reset_active = in_reset;

	// mode capture, refreshed on every cycle of reset
	logic [1:0] mode, next_mode;
	logic mode_valid, next_mode_valid;
	logic lir_oe, next_lir_oe;
	// sync_2 holds its reset value until the second edge, so mode waits for real pin levels
	logic [1:0] settle, next_settle;

	always_comb begin
		next_mode = mode;
		if (in_reset || !mode_valid) begin
			next_mode = {sync_2[mcp_pkg::SY_MODE_HI], sync_2[mcp_pkg::SY_MODE_LO]};
		end
		next_settle = {settle[0], 1'b1};
		next_mode_valid = !in_reset && settle[1];
		next_lir_oe = mode_valid && !in_reset && i_opcode_fetch;
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			mode <= mcp_pkg::MODE_BOOTSTRAP;
			mode_valid <= 1'b0;
			settle <= 2'h0;
			lir_oe <= 1'b0;
		end else begin
			mode <= next_mode;
			mode_valid <= next_mode_valid;
			settle <= next_settle;
			lir_oe <= next_lir_oe;
		end
	end

	assign o_mode = mode;
	assign o_mode_select_low = 1'b0;
	assign o_mode_select_low_oe = lir_oe;

	// bus-phase clock divider
	logic [1:0] phase, next_phase;
	logic e_int, next_e_int;
	logic e_out, next_e_out;
	logic clk_running;
	logic single_chip;
	logic clk_out_en;
	logic [mcp_pkg::CTRL_W-1:0] ctrl, next_ctrl;

	// stop cannot freeze the reset sequencer, which counts bus cycles
	assign clk_running = !i_stop || in_reset;
	assign single_chip = (mode == mcp_pkg::MODE_BOOTSTRAP) || (mode == mcp_pkg::MODE_SINGLE);
	assign clk_out_en = CLOCK_OUT_ALWAYS_ON || !(ctrl[mcp_pkg::CTRL_CLK_OFF] && single_chip);
	assign bus_tick = clk_running && (phase == mcp_pkg::PHASE_LAST);

	always_comb begin
		next_phase = phase;
		if (clk_running) begin
			next_phase = phase + 2'h1;
		end
		next_e_int = clk_running && (next_phase >= mcp_pkg::PHASE_HIGH_START);
		next_e_out = next_e_int && clk_out_en;
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			phase <= 2'h0;
			e_int <= 1'b0;
			e_out <= 1'b0;
		end else begin
			phase <= next_phase;
			e_int <= next_e_int;
			e_out <= next_e_out;
		end
	end

	assign o_bus_clock = e_out;
	assign o_access_phase = e_int;
	assign o_bus_cycle_end = bus_tick;

	// maskable and nonmaskable interrupt paths
	logic irq_low_d, next_irq_low_d;
	logic nmi_low_d, next_nmi_low_d;
	logic irq_latch, next_irq_latch;
	logic xmask, next_xmask;
	logic irq_fall;
	logic irq_req;
	logic xmask_clear;

	assign irq_fall = irq_low && !irq_low_d;

	always_comb begin
		next_irq_low_d = irq_low;
		next_nmi_low_d = nmi_low;
		// a new edge in the ack cycle is kept
		next_irq_latch = (irq_latch && !i_irq_ack) || (ctrl[mcp_pkg::CTRL_IRQ_EDGE] && irq_fall);
		if (!ctrl[mcp_pkg::CTRL_IRQ_EDGE]) begin
			next_irq_latch = 1'b0;
		end
		next_xmask = xmask && !xmask_clear;
		if (in_reset) begin
			next_xmask = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			irq_low_d <= 1'b0;
			nmi_low_d <= 1'b0;
			irq_latch <= 1'b0;
			xmask <= 1'b1;
		end else begin
			irq_low_d <= next_irq_low_d;
			nmi_low_d <= next_nmi_low_d;
			irq_latch <= next_irq_latch;
			xmask <= next_xmask;
		end
	end

	// level mode re-asserts by itself once the cpu mask bit drops
	assign irq_req = ctrl[mcp_pkg::CTRL_IRQ_EDGE] ? irq_latch : irq_low;
	assign o_cpu_irq = irq_req && !i_irq_mask && !in_reset;
	assign o_cpu_nmi = nmi_low && !xmask && !in_reset;

	// wishbone slave, one wait state then ack
	logic ack, next_ack;
	logic [31:0] rdat, next_rdat;
	logic [mcp_pkg::ST_W-1:0] status, next_status;
	logic [mcp_pkg::ST_W-1:0] mask, next_mask;
	logic [mcp_pkg::ST_W-1:0] events;
	logic access;
	logic wr_byte0;
	logic rd_status;

	assign access = i_wb_cyc && i_wb_stb && !ack;
	assign wr_byte0 = access && i_wb_we && i_wb_sel[0];
	assign rd_status = access && !i_wb_we && (i_wb_adr == mcp_pkg::OFF_STATUS);
	assign xmask_clear = wr_byte0 && (i_wb_adr == mcp_pkg::OFF_FLAGS)
		&& i_wb_dat[mcp_pkg::FLAGS_XMASK];

	always_comb begin
		events = '0;
		events[mcp_pkg::ST_IRQ] = irq_fall;
		events[mcp_pkg::ST_NMI] = nmi_low && !nmi_low_d && !xmask;
		events[mcp_pkg::ST_RST_INT] = ev_rst_int;
		events[mcp_pkg::ST_RST_EXT] = ev_rst_ext;
	end

	always_comb begin
		next_ack = access;
		next_ctrl = ctrl;
		next_mask = mask;
		next_rdat = 32'h0;
		// read clear first, new events after, so a coinciding event stays
		next_status = (rd_status ? '0 : status) | events;
		if (wr_byte0 && (i_wb_adr == mcp_pkg::OFF_CTRL)) begin
			next_ctrl = i_wb_dat[mcp_pkg::CTRL_W-1:0];
		end
		if (wr_byte0 && (i_wb_adr == mcp_pkg::OFF_MASK)) begin
			next_mask = i_wb_dat[mcp_pkg::ST_W-1:0];
		end
		if (access && !i_wb_we) begin
			unique case (i_wb_adr)
				mcp_pkg::OFF_CTRL: next_rdat[mcp_pkg::CTRL_W-1:0] = ctrl;
				mcp_pkg::OFF_FLAGS: next_rdat[mcp_pkg::FLAGS_XMASK] = xmask;
				mcp_pkg::OFF_STATUS: next_rdat[mcp_pkg::ST_W-1:0] = status;
				mcp_pkg::OFF_MASK: next_rdat[mcp_pkg::ST_W-1:0] = mask;
				mcp_pkg::OFF_INFO: begin
					next_rdat[mcp_pkg::INFO_MODE_LSB +: 2] = mode;
					next_rdat[mcp_pkg::INFO_CAUSE_LSB +: 2] = cause;
					next_rdat[mcp_pkg::INFO_RST_ACTIVE] = in_reset;
					next_rdat[mcp_pkg::INFO_CLK_ON] = clk_out_en;
				end
				default: next_rdat = 32'h0;
			endcase
		end
		if (in_reset) begin
			next_ctrl = mcp_pkg::CTRL_RESET;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ack <= 1'b0;
			rdat <= 32'h0;
			ctrl <= mcp_pkg::CTRL_RESET;
			mask <= mcp_pkg::MASK_RESET;
			status <= mcp_pkg::STATUS_RESET;
		end else begin
			ack <= next_ack;
			rdat <= next_rdat;
			ctrl <= next_ctrl;
			mask <= next_mask;
			status <= next_status;
		end
	end

	assign o_wb_ack = ack;
	assign o_wb_dat = rdat;
	assign o_irq = |(status & mask);
endmodule : mcp_control_pins

/* File: verif/mcp_control_pins_monitor.sv */
`timescale 1ns/1ps
module mcp_control_pins_monitor (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_stop,
	input wire logic i_irq_n,
	input wire logic i_irq_ack,
	input wire logic i_irq_mask,
	input wire logic i_nonmaskable_interrupt_request_n,
	input wire logic i_opcode_fetch,
	input wire logic i_clock_monitor_fail,
	input wire logic i_watchdog_monitor_fail,
	input wire logic o_reset_pin_oe,
	input wire logic o_reset_active,
	input wire logic o_bus_clock,
	input wire logic o_access_phase,
	input wire logic o_bus_cycle_end,
	input wire logic o_cpu_irq,
	input wire logic o_cpu_nmi,
	input wire logic o_mode_select_low_oe,
	input wire logic [1:0] o_mode
);
	// divider history is trusted only after 7 cycles free of stop and reset
	logic [2:0] run_cnt;
	logic [2:0] next_run_cnt;
	always_comb next_run_cnt = i_stop ? 3'h0 : run_cnt + {2'h0, run_cnt != 3'h7};
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			run_cnt <= 3'h0;
		end else begin
			run_cnt <= next_run_cnt;
		end
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	property p_fail_pull;
		(i_watchdog_monitor_fail || i_clock_monitor_fail) && !o_reset_active |=> o_reset_pin_oe;
	endproperty
	a_fail_pull: assert property (p_fail_pull) else $error("no pull on failure");
	property p_pull_hold;
		$rose(o_reset_pin_oe) |-> (o_reset_pin_oe && o_reset_active)[*8];
	endproperty
	a_pull_hold: assert property (p_pull_hold) else $error("pull too short");
	property p_quarter;
		$rose(o_access_phase) && run_cnt == 3'h7
			|-> $past(o_access_phase, 4) && $past(o_access_phase, 3) && !$past(o_access_phase, 2);
	endproperty
	a_quarter: assert property (p_quarter) else $error("phase clock not div 4");
	property p_gated;
		o_bus_clock |-> o_access_phase;
	endproperty
	a_gated: assert property (p_gated) else $error("clock out off phase");
	property p_cycle_end;
		o_bus_cycle_end && run_cnt == 3'h7 |-> o_access_phase ##1 !o_access_phase;
	endproperty
	a_cycle_end: assert property (p_cycle_end) else $error("cycle end off phase");
	property p_stop;
		(i_stop && !o_reset_active)[*3] |-> !o_bus_clock;
	endproperty
	a_stop: assert property (p_stop) else $error("clock runs in stop");
	property p_irq_lat;
		$fell(i_irq_n) ##1 (!i_irq_n && !i_irq_mask && !i_irq_ack)[*3] |-> o_cpu_irq;
	endproperty
	a_irq_lat: assert property (p_irq_lat) else $error("irq not taken");
	property p_nmi;
		$rose(o_cpu_nmi) |-> !o_reset_active && !$past(i_nonmaskable_interrupt_request_n, 2);
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi without cause");
	property p_lir;
		(!o_reset_active)[*6] ##0 (i_opcode_fetch && run_cnt == 3'h7) |=> o_mode_select_low_oe;
	endproperty
	a_lir: assert property (p_lir) else $error("no fetch flag");
	property p_mode_hold;
		(!o_reset_active)[*6] ##0 run_cnt == 3'h7 |-> $stable(o_mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
	c_pull: cover property ($rose(o_reset_pin_oe));
	c_nmi: cover property ($rose(o_cpu_nmi));
	c_lir: cover property ($rose(o_mode_select_low_oe));
endmodule : mcp_control_pins_monitor

/* File: verif/mcp_pins_partner.sv */
`timescale 1ns/1ps
module mcp_pins_partner (
	input wire logic i_clk_sys,
	input wire logic i_pull_oe,
	input wire logic i_lir_oe,
	input wire logic i_hold,
	input wire logic i_raise,
	input wire logic i_served,
	input wire logic i_strap,
	output logic o_reset_pin,
	output logic o_irq_n,
	output logic o_mode_low,
	output logic [7:0] o_fetches
);
	logic pend = 1'b0;
	logic lir_d = 1'b0;
	logic [7:0] cnt = 8'h0;
	// pulled-up open-drain lines: low while any party pulls
	assign o_reset_pin = !(i_pull_oe || i_hold);
	assign o_irq_n = !pend;
	assign o_mode_low = i_strap && !i_lir_oe;
	assign o_fetches = cnt;
	always_ff @(posedge i_clk_sys) begin
		pend <= i_raise || (pend && !i_served);
		lir_d <= i_lir_oe;
		cnt <= cnt + {7'h0, i_lir_oe && !lir_d};
	end
endmodule : mcp_pins_partner

/* File: verif/mcp_control_pins_bench.sv */
`timescale 1ns/1ps
module mcp_control_pins_bench;
	logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic cmon = 1'b0, wdog = 1'b0, stop = 1'b0, iack = 1'b0, imask = 1'b0, nmi_n = 1'b1;
	logic fetch = 1'b0, hold = 1'b0, raise = 1'b0, served = 1'b0, strap = 1'b0, hi = 1'b1;
	logic [7:0] adr = 8'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat, q;
	logic ack, irq, pull_oe, ract, bclk, aph, cirq, cnmi, lir_oe, rpin, irq_n, mlow, sh;
	logic [1:0] mode;
	logic [7:0] fetches;
	int n_errors = 0, n_tests = 0, cycles = 0;
	int n_rise = 0, n_high = 0;
	always #10 clk = !clk;
	mcp_control_pins i_mcp_control_pins (
		.i_clk_sys(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
		.o_irq(irq), .i_reset_pin(rpin), .o_reset_pin(), .o_reset_pin_oe(pull_oe),
		.i_clock_monitor_fail(cmon), .i_watchdog_monitor_fail(wdog), .o_reset_active(ract),
		.i_stop(stop), .o_bus_clock(bclk), .o_access_phase(aph), .o_bus_cycle_end(),
		.i_irq_n(irq_n), .i_irq_ack(iack), .i_irq_mask(imask), .o_cpu_irq(cirq),
		.i_nonmaskable_interrupt_request_n(nmi_n), .o_cpu_nmi(cnmi),
		.i_mode_select_low(mlow), .o_mode_select_low(), .o_mode_select_low_oe(lir_oe),
		.i_mode_select_high(hi), .i_opcode_fetch(fetch), .o_mode(mode));
	mcp_pins_partner i_mcp_pins_partner (.i_clk_sys(clk), .i_pull_oe(pull_oe), .i_lir_oe(lir_oe),
		.i_hold(hold), .i_raise(raise), .i_served(served), .i_strap(strap),
		.o_reset_pin(rpin), .o_irq_n(irq_n), .o_mode_low(mlow), .o_fetches(fetches));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		check(q, e);
	endtask : rd
	// the sequencer may take a while to release, so the wait is bounded
	task automatic wait_idle;
		int k;
		k = 0;
		while (ract !== 1'b0 && k < 300) begin
			@(posedge clk);
			k++;
		end
		check(ract, 1'b0);
	endtask : wait_idle
	task automatic results;
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		tick(20);
		rst <= 1'b0;
		tick(2);
		rd(mcp_pkg::OFF_CTRL, 32'h0);
		rd(mcp_pkg::OFF_FLAGS, 32'h1);
		rd(mcp_pkg::OFF_INFO, 32'h202);
		rd(8'h40, 32'h0);
		nmi_n <= 1'b0;
		tick(4);
		check(cnmi, 1'b0);
		wb(1'b1, mcp_pkg::OFF_FLAGS, 32'h1);
		tick(3);
		check(cnmi, 1'b1);
		nmi_n <= 1'b1;
		tick(3);
		nmi_n <= 1'b0;
		tick(3);
		nmi_n <= 1'b1;
		check(irq, 1'b0);
		wb(1'b1, mcp_pkg::OFF_MASK, 32'hf);
		tick(1);
		check(irq, 1'b1);
		rd(mcp_pkg::OFF_STATUS, 32'h2);
		tick(1);
		check(irq, 1'b0);
		imask <= 1'b1;
		raise <= 1'b1;
		tick(1);
		raise <= 1'b0;
		tick(4);
		check(cirq, 1'b0);
		imask <= 1'b0;
		tick(1);
		check(cirq, 1'b1);
		served <= 1'b1;
		tick(1);
		served <= 1'b0;
		tick(4);
		check(cirq, 1'b0);
		wb(1'b1, mcp_pkg::OFF_CTRL, 32'h1);
		raise <= 1'b1;
		tick(1);
		raise <= 1'b0;
		tick(4);
		check(cirq, 1'b1);
		iack <= 1'b1;
		tick(1);
		iack <= 1'b0;
		tick(2);
		check({cirq, irq_n}, 2'b00);
		served <= 1'b1;
		tick(1);
		served <= 1'b0;
		rd(mcp_pkg::OFF_STATUS, 32'h1);
		for (int k = 0; k < 2; k++) begin
			cmon <= (k == 0);
			wdog <= (k == 1);
			tick(1);
			cmon <= 1'b0;
			wdog <= 1'b0;
			tick(2);
			check({pull_oe, rpin}, 2'b10);
			tick(4);
			wait_idle();
			rd(mcp_pkg::OFF_STATUS, 32'h4);
			rd(mcp_pkg::OFF_INFO, 32'h222 + 32'(k) * 32'h10);
			rd(mcp_pkg::OFF_FLAGS, 32'h1);
			rd(mcp_pkg::OFF_CTRL, 32'h0);
		end
		for (int m = 3; m >= 0; m--) begin
			hi <= m[1];
			strap <= m[0];
			hold <= 1'b1;
			tick(30);
			hold <= 1'b0;
			tick(4);
			wait_idle();
			rd(mcp_pkg::OFF_STATUS, 32'h8);
			hi <= !m[1];
			strap <= !m[0];
			wb(1'b1, mcp_pkg::OFF_CTRL, 32'h2);
			sh = 1'b0;
			repeat (8) begin
				@(posedge clk);
				sh = sh | bclk;
			end
			check(sh, m[0]);
			rd(mcp_pkg::OFF_INFO, 32'(m) + 32'h10 + 32'(m[0]) * 32'h200);
			check(mode, m[1:0]);
		end
		hold <= 1'b1;
		tick(3);
		hold <= 1'b0;
		tick(4);
		wait_idle();
		rd(mcp_pkg::OFF_STATUS, 32'h4);
		rd(mcp_pkg::OFF_INFO, 32'h203);
		@(posedge clk);
		sh = bclk;
		repeat (40) begin
			@(posedge clk);
			if (bclk && !sh) n_rise++;
			if (bclk) n_high++;
			sh = bclk;
		end
		check(n_rise, 32'ha);
		check(n_high, 32'h14);
		stop <= 1'b1;
		tick(3);
		sh = 1'b0;
		repeat (8) begin
			@(posedge clk);
			sh = sh | bclk;
		end
		check(sh, 1'b0);
		stop <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			fetch <= 1'b1;
			tick(1);
			fetch <= 1'b0;
			tick(4);
		end
		check(fetches, 8'h3);
		results();
	end
endmodule : mcp_control_pins_bench
bind mcp_control_pins mcp_control_pins_monitor i_mcp_control_pins_monitor (.i_clk_sys, .i_reset,
	.i_stop, .i_irq_n, .i_irq_ack, .i_irq_mask, .i_nonmaskable_interrupt_request_n,
	.i_opcode_fetch, .i_clock_monitor_fail, .i_watchdog_monitor_fail, .o_reset_pin_oe,
	.o_reset_active, .o_bus_clock, .o_access_phase, .o_bus_cycle_end, .o_cpu_irq, .o_cpu_nmi,
	.o_mode_select_low_oe, .o_mode);
